//--- core/tse_top.v
// soft event generation timer: register port, counter, update and channel events
//
// What this block does
// - writing one to channel 0 request bit fires a channel 0 event; zero does nothing
// - a channel 0 soft event sets its flag and the enabled interrupt or dma request
// - input mode: event captures counter; flag already set also sets overcapture
// - channels 1 to 3 request bits behave alike, ch1 at bit 2, ch3 at bit 4
// - update request bit self clears once the update event is generated
// - soft update clears the counter in up or center-aligned counting
// - soft update loads the auto-reload value in down counting
// - soft update clears the prescaler counter in the same cycle
// - every update event sets the update flag, cleared only by software
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "tse_defs.vh"

module tse_top (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [31:0] reg_rdata_o,
  output wire        irq_o,
  output wire [4:0]  dma_req_o,
  output wire        update_event_o,
  output wire [3:0]  chan_event_o,
  output wire [15:0] cnt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////////////////

  reg  [6:0]  ctrl_q;
  reg  [20:0] inten_q;
  reg  [15:0] chctl0_q;
  reg  [15:0] chctl1_q;
  reg  [15:0] cnt_q;
  reg  [15:0] cnt_d;
  reg  [15:0] psc_q;
  reg  [15:0] pcnt_q;
  reg  [15:0] pcnt_d;
  reg  [15:0] car_q;
  reg         cdir_q;
  reg         cdir_d;
  reg         hw_upd;
  reg         upd_flag_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg  [4:0]  dma_q;
  reg         upd_evt_q;
  reg  [3:0]  chan_evt_q;

  wire [3:0]  chan_req;
  wire        upd_req;
  wire        upd_evt;
  wire [3:0]  in_mode;
  wire [3:0]  flag;
  wire [3:0]  ovc;
  wire [63:0] cv_flat;
  wire [12:0] intf;
  wire [12:0] intf_clr;
  wire [3:0]  cv_wr;
  wire [3:0]  cv_rd;
  wire        center;
  wire        down;

  integer     k;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  ////////////////////////////////////////////////////////////////////////////

  // any non-zero mode selection routes the channel to an input
  function is_input;
    input [1:0] ms;
    begin
      is_input = (ms != 2'b00);
    end
  endfunction

  // address of the value register of channel n
  function cv_hit;
    input [7:0] a;
    input [1:0] n;
    begin
      cv_hit = (a == (`TSE_OFF_CV0 + {4'h0, n, 2'b00}));
    end
  endfunction

  // write strobe aimed at one register
  function wr_hit;
    input       wr;
    input [7:0] a;
    input [7:0] off;
    begin
      wr_hit = wr && (a == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // soft event requests
  ////////////////////////////////////////////////////////////////////////////

  // request bits never store; they act in the write cycle and read back zero,
  // so hardware clearing is implicit and no request can be lost or repeated
  assign upd_req  = wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_SWEVG)
                    && reg_wdata_i[`TSE_EVG_UPD];
  assign chan_req = wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_SWEVG)
                    ? reg_wdata_i[`TSE_EVG_CH3:`TSE_EVG_CH0]
                    : 4'h0;
  assign upd_evt  = upd_req | hw_upd;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  ////////////////////////////////////////////////////////////////////////////

  // count enable, direction and center-aligned mode
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= `TSE_RST_CTRL;
    end else if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_CTRL)) begin
      ctrl_q <= reg_wdata_i[6:0] & `TSE_CTRL_WMASK;
    end
  end

  // interrupt mask in bits 12:0, dma enables in bits 20:16
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      inten_q <= `TSE_RST_INTEN;
    end else if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_INTEN)) begin
      inten_q <= reg_wdata_i[20:0] & `TSE_INTEN_WMSK;
    end
  end

  // channel mode words; only whole-word writes are decoded, no byte lanes
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      chctl0_q <= `TSE_RST_CHCTL;
      chctl1_q <= `TSE_RST_CHCTL;
    end else begin
      if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_CHCTL0)) begin
        chctl0_q <= reg_wdata_i[15:0] & `TSE_CHCTL_WMSK;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_CHCTL1)) begin
        chctl1_q <= reg_wdata_i[15:0] & `TSE_CHCTL_WMSK;
      end
    end
  end

  // prescaler and auto-reload value
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      psc_q <= `TSE_RST_PSC;
      car_q <= `TSE_RST_CAR;
    end else begin
      if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_PSC)) begin
        psc_q <= reg_wdata_i[15:0];
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_CAR)) begin
        car_q <= reg_wdata_i[15:0];
      end
    end
  end

  assign in_mode[0] = is_input(chctl0_q[`TSE_MS0]);
  assign in_mode[1] = is_input(chctl0_q[`TSE_MS1]);
  assign in_mode[2] = is_input(chctl1_q[`TSE_MS0]);
  assign in_mode[3] = is_input(chctl1_q[`TSE_MS1]);

  assign center = (ctrl_q[`TSE_CTRL_CAM] != 2'b00);
  assign down   = ctrl_q[`TSE_CTRL_DIR];

  ////////////////////////////////////////////////////////////////////////////
  // counter and prescaler
  ////////////////////////////////////////////////////////////////////////////

  // next counter value; a soft update overrides counting and a software write
  always @* begin
    cnt_d  = cnt_q;
    pcnt_d = pcnt_q;
    cdir_d = cdir_q;
    hw_upd = 1'b0;
    if (upd_req) begin
      pcnt_d = 16'h0000;
      cdir_d = 1'b0;
      if (down && !center) begin
        cnt_d = car_q;
      end else begin
        cnt_d = 16'h0000;
      end
    end else if (wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_CNT)) begin
      cnt_d = reg_wdata_i[15:0];
    end else if (ctrl_q[`TSE_CTRL_EN]) begin
      if (pcnt_q != psc_q) begin
        pcnt_d = pcnt_q + 16'h0001;
      end else begin
        pcnt_d = 16'h0000;
        if (center) begin
          // up then down; a zero reload would stall here, so it holds at zero
          if (car_q == 16'h0000) begin
            cnt_d  = 16'h0000;
            hw_upd = 1'b1;
          end else if (!cdir_q) begin
            if (cnt_q >= car_q) begin
              cnt_d  = car_q - 16'h0001;
              cdir_d = 1'b1;
              hw_upd = 1'b1;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end else begin
            if (cnt_q == 16'h0000) begin
              cnt_d  = 16'h0001;
              cdir_d = 1'b0;
              hw_upd = 1'b1;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end else if (down) begin
          if (cnt_q == 16'h0000) begin
            cnt_d  = car_q;
            hw_upd = 1'b1;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end else begin
          if (cnt_q >= car_q) begin
            cnt_d  = 16'h0000;
            hw_upd = 1'b1;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
      end
    end
  end

  // counter state
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_q  <= `TSE_RST_CNT;
      pcnt_q <= 16'h0000;
      cdir_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      pcnt_q <= pcnt_d;
      cdir_q <= cdir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and requests
  ////////////////////////////////////////////////////////////////////////////

  assign intf_clr = wr_hit(reg_wr_i, reg_addr_i, `TSE_OFF_INTF)
                    ? reg_wdata_i[12:0]
                    : 13'h0000;

  // update flag: set wins over a write-one clear in the same cycle
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      upd_flag_q <= 1'b0;
    end else if (upd_evt) begin
      upd_flag_q <= 1'b1;
    end else if (intf_clr[`TSE_INTF_UPD]) begin
      upd_flag_q <= 1'b0;
    end
  end

  // one-cycle event and dma pulses, registered at the same edge as the counter update
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      dma_q      <= 5'h00;
      upd_evt_q  <= 1'b0;
      chan_evt_q <= 4'h0;
    end else begin
      dma_q      <= {chan_req, upd_evt} & inten_q[`TSE_INTEN_DMA];
      upd_evt_q  <= upd_evt;
      chan_evt_q <= chan_req;
    end
  end

  assign intf = {ovc, 4'h0, flag, upd_flag_q};

  ////////////////////////////////////////////////////////////////////////////
  // channels
  ////////////////////////////////////////////////////////////////////////////

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      assign cv_wr[g] = reg_wr_i && cv_hit(reg_addr_i, g[1:0]);
      assign cv_rd[g] = reg_rd_i && cv_hit(reg_addr_i, g[1:0]);
      tse_chan u_chan (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .soft_evt_i (chan_req[g]),
        .in_mode_i  (in_mode[g]),
        .cnt_i      (cnt_q),
        .cv_wr_i    (cv_wr[g]),
        .cv_wdata_i (reg_wdata_i[15:0]),
        .cv_rd_i    (cv_rd[g]),
        .flag_clr_i (intf_clr[1 + g]),
        .of_clr_i   (intf_clr[9 + g]),
        .cv_o       (cv_flat[16*g +: 16]),
        .flag_o     (flag[g]),
        .of_o       (ovc[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port
  ////////////////////////////////////////////////////////////////////////////

  // read mux; the request register and unmapped offsets read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr_i)
      `TSE_OFF_CTRL: begin
        rdata_d = {25'h0000000, ctrl_q};
      end
      `TSE_OFF_INTEN: begin
        rdata_d = {11'h000, inten_q};
      end
      `TSE_OFF_INTF: begin
        rdata_d = {19'h00000, intf};
      end
      `TSE_OFF_CHCTL0: begin
        rdata_d = {16'h0000, chctl0_q};
      end
      `TSE_OFF_CHCTL1: begin
        rdata_d = {16'h0000, chctl1_q};
      end
      `TSE_OFF_CNT: begin
        rdata_d = {16'h0000, cnt_q};
      end
      `TSE_OFF_PSC: begin
        rdata_d = {16'h0000, psc_q};
      end
      `TSE_OFF_CAR: begin
        rdata_d = {16'h0000, car_q};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
    for (k = 0; k < 4; k = k + 1) begin
      if (cv_rd[k]) begin
        rdata_d = {16'h0000, cv_flat[16*k +: 16]};
      end
    end
  end

  // data stands only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////////////////////

  assign reg_rdata_o    = rdata_q;
  assign irq_o          = |(intf & inten_q[`TSE_INTEN_IRQ]);
  assign dma_req_o      = dma_q;
  assign update_event_o = upd_evt_q;
  assign chan_event_o   = chan_evt_q;
  assign cnt_o          = cnt_q;

endmodule

//--- common/tse_defs.vh
// register offsets, field positions and reset values of the soft event timer
`ifndef TSE_DEFS_VH
`define TSE_DEFS_VH

`define TSE_OFF_CTRL   8'h00
`define TSE_OFF_INTEN  8'h0c
`define TSE_OFF_INTF   8'h10
`define TSE_OFF_SWEVG  8'h14
`define TSE_OFF_CHCTL0 8'h18
`define TSE_OFF_CHCTL1 8'h1c
`define TSE_OFF_CNT    8'h24
`define TSE_OFF_PSC    8'h28
`define TSE_OFF_CAR    8'h2c
`define TSE_OFF_CV0    8'h34

`define TSE_EVG_UPD    0
`define TSE_EVG_CH0    1
`define TSE_EVG_CH3    4

`define TSE_CTRL_EN    0
`define TSE_CTRL_DIR   4
`define TSE_CTRL_CAM   6:5
`define TSE_CTRL_WMASK 7'h71

`define TSE_INTF_UPD   0
`define TSE_INTF_CH    4:1
`define TSE_INTF_OF    12:9
`define TSE_INTEN_IRQ  12:0
`define TSE_INTEN_DMA  20:16
`define TSE_INTEN_WMSK 21'h1f1e1f

`define TSE_CHCTL_WMSK 16'hffff
`define TSE_MS0        1:0
`define TSE_MS1        9:8

`define TSE_RST_CTRL   7'h00
`define TSE_RST_INTEN  21'h000000
`define TSE_RST_CHCTL  16'h0000
`define TSE_RST_CNT    16'h0000
`define TSE_RST_PSC    16'h0000
`define TSE_RST_CAR    16'hffff
`define TSE_RST_CV     16'h0000

`endif

//--- core/tse_chan.v
// one capture/compare channel: value register, event flag, overcapture flag
`timescale 1ns/1ps
`include "tse_defs.vh"

module tse_chan (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        soft_evt_i,
  input  wire        in_mode_i,
  input  wire [15:0] cnt_i,
  input  wire        cv_wr_i,
  input  wire [15:0] cv_wdata_i,
  input  wire        cv_rd_i,
  input  wire        flag_clr_i,
  input  wire        of_clr_i,
  output wire [15:0] cv_o,
  output wire        flag_o,
  output wire        of_o
);

  reg [15:0] cv_q;
  reg        flag_q;
  reg        of_q;

  // capture on a soft event in input mode; compare value only writable in output mode
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      cv_q <= `TSE_RST_CV;
    end else if (soft_evt_i && in_mode_i) begin
      cv_q <= cnt_i;
    end else if (cv_wr_i && !in_mode_i) begin
      cv_q <= cv_wdata_i;
    end
  end

  // event flag: the soft event sets it and wins over a clear in the same cycle
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
    end else if (soft_evt_i) begin
      flag_q <= 1'b1;
    end else if (flag_clr_i || (cv_rd_i && in_mode_i)) begin
      flag_q <= 1'b0;
    end
  end

  // overcapture: a capture finds the previous one still unacknowledged
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      of_q <= 1'b0;
    end else if (soft_evt_i && in_mode_i && flag_q) begin
      of_q <= 1'b1;
    end else if (of_clr_i) begin
      of_q <= 1'b0;
    end
  end

  assign cv_o   = cv_q;
  assign flag_o = flag_q;
  assign of_o   = of_q;

endmodule

//--- bench/tse_monitor.sv
// port level checks of the soft event timer
`timescale 1ns/1ps
`include "tse_defs.vh"

module tse_monitor (
  input wire        core_clk_i,
  input wire        reset_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        irq_o,
  input wire [4:0]  dma_req_o,
  input wire        update_event_o,
  input wire [3:0]  chan_event_o,
  input wire [15:0] cnt_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////////
  // a write to the soft event request register
  wire soft_wr = reg_wr_i && (reg_addr_i == `TSE_OFF_SWEVG);

  // read data only stand in the cycle after a read strobe
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  wo_read_a: assert property (reg_rd_i && reg_addr_i == `TSE_OFF_SWEVG |=> reg_rdata_o == 32'h0)
    else $error("request register read back nonzero");
  // request bits act once and never linger
  upd_evt_a: assert property (soft_wr && reg_wdata_i[0] |=> update_event_o)
    else $error("no update event after request");
  chan_evt_a: assert property (1'b1 |=> chan_event_o ==
    ($past(soft_wr) ? $past(reg_wdata_i[4:1]) : 4'h0))
    else $error("channel events do not match request bits");
  all_evt_a: assert property (soft_wr && reg_wdata_i[4:0] == 5'h1f |=>
    update_event_o && chan_event_o == 4'hf)
    else $error("combined request not done in one cycle");
  dma_ch_a: assert property ((dma_req_o[4:1] & ~chan_event_o) == 4'h0)
    else $error("channel dma request without channel event");
  dma_upd_a: assert property (dma_req_o[0] |-> update_event_o)
    else $error("update dma request without update event");
  // flags only come from writes or update events, so irq rises only after them
  irq_src_a: assert property ($rose(irq_o) |-> $past(reg_wr_i) || update_event_o)
    else $error("interrupt rose without a cause");
endmodule

bind tse_top tse_monitor u_mon (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .dma_req_o, .update_event_o,
  .chan_event_o, .cnt_o);

//--- bench/timer_soft_event_generation_tb.sv
// register level testbench of the soft event timer
`timescale 1ns/1ps
`include "tse_defs.vh"

module timer_soft_event_generation_tb;
  reg         core_clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg  [7:0]  reg_addr_i = 8'h00;
  reg  [31:0] reg_wdata_i = 32'h0;
  reg         reg_wr_i = 1'b0;
  reg         reg_rd_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire        irq_o;
  wire [4:0]  dma_req_o;
  wire        update_event_o;
  wire [3:0]  chan_event_o;
  wire [15:0] cnt_o;
  integer     n_fail = 0;
  integer     compares = 0;
  reg  [31:0] rd_v;

  always #5 core_clk_i = ~core_clk_i;

  tse_top uut (
    .core_clk_i     (core_clk_i),
    .reset_i        (reset_i),
    .reg_addr_i     (reg_addr_i),
    .reg_wdata_i    (reg_wdata_i),
    .reg_wr_i       (reg_wr_i),
    .reg_rd_i       (reg_rd_i),
    .reg_rdata_o    (reg_rdata_o),
    .irq_o          (irq_o),
    .dma_req_o      (dma_req_o),
    .update_event_o (update_event_o),
    .chan_event_o   (chan_event_o),
    .cnt_o          (cnt_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one cycle write; returns just after the taking edge
  task wr_reg(input [7:0] a, input [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // data stand only in the cycle after the strobe, so sample right then
  task rd_reg(input [7:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_v = reg_rdata_o;
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task complete_run;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_fail = n_fail + 1;
    complete_run;
  end

  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd_reg(`TSE_OFF_CAR);
    chk("car reset", rd_v, 32'h0000ffff);
    rd_reg(`TSE_OFF_CHCTL0);
    chk("chctl0 reset", rd_v, 32'h0);
    // soft update in up counting clears a preset counter
    wr_reg(`TSE_OFF_CAR, 32'h20);
    wr_reg(`TSE_OFF_CNT, 32'h5);
    wr_reg(`TSE_OFF_SWEVG, 32'h1);
    chk("cnt up", cnt_o, 16'h0);
    chk("update pulse", update_event_o, 1'b1);
    rd_reg(`TSE_OFF_SWEVG);
    chk("request readback", rd_v, 32'h0);
    rd_reg(`TSE_OFF_INTF);
    chk("update flag", rd_v, 32'h1);
    wr_reg(`TSE_OFF_INTF, 32'h1);
    rd_reg(`TSE_OFF_INTF);
    chk("update flag clear", rd_v, 32'h0);
    // down counting reloads, center aligned clears
    wr_reg(`TSE_OFF_CTRL, 32'h10);
    wr_reg(`TSE_OFF_CNT, 32'h5);
    wr_reg(`TSE_OFF_SWEVG, 32'h1);
    chk("cnt down", cnt_o, 16'h20);
    // center aligned clears even with the down bit set
    wr_reg(`TSE_OFF_CTRL, 32'h30);
    wr_reg(`TSE_OFF_SWEVG, 32'h1);
    chk("cnt center", cnt_o, 16'h0);
    // a cleared prescaler gives a full eight cycle step after the update
    wr_reg(`TSE_OFF_PSC, 32'h7);
    wr_reg(`TSE_OFF_CTRL, 32'h1);
    cyc(3);
    wr_reg(`TSE_OFF_SWEVG, 32'h1);
    cyc(5);
    chk("cnt held", cnt_o, 16'h0);
    cyc(4);
    chk("cnt stepped", cnt_o, 16'h1);
    wr_reg(`TSE_OFF_CTRL, 32'h0);
    wr_reg(`TSE_OFF_INTF, 32'hffff);
    // channels 0 and 1 capture, 2 and 3 compare; all four plus update in one write
    wr_reg(`TSE_OFF_CHCTL0, 32'h0101);
    wr_reg(`TSE_OFF_CNT, 32'h33);
    wr_reg(`TSE_OFF_INTEN, 32'h1f001e);
    wr_reg(`TSE_OFF_SWEVG, 32'h1f);
    chk("dma pulses", dma_req_o, 5'h1f);
    chk("chan pulses", chan_event_o, 4'hf);
    chk("cnt same cycle", cnt_o, 16'h0);
    rd_reg(`TSE_OFF_INTF);
    chk("chan flags", rd_v, 32'h1f);
    chk("irq set", irq_o, 1'b1);
    rd_reg(`TSE_OFF_CV0);
    chk("cv0 capture", rd_v, 32'h33);
    rd_reg(8'h3c);
    chk("cv2 no capture", rd_v, 32'h0);
    wr_reg(`TSE_OFF_CNT, 32'h44);
    wr_reg(`TSE_OFF_SWEVG, 32'h4);
    rd_reg(`TSE_OFF_INTF);
    chk("ch1 overcapture", rd_v, 32'h41d);
    wr_reg(`TSE_OFF_SWEVG, 32'h0);
    rd_reg(`TSE_OFF_INTF);
    chk("zero request", rd_v, 32'h41d);
    rd_reg(8'h38);
    chk("cv1 capture", rd_v, 32'h44);
    // masked event sets the flag but not irq or dma
    wr_reg(`TSE_OFF_INTF, 32'hffff);
    chk("irq cleared", irq_o, 1'b0);
    wr_reg(`TSE_OFF_INTEN, 32'h0);
    wr_reg(`TSE_OFF_SWEVG, 32'h2);
    chk("dma masked", dma_req_o, 5'h0);
    chk("irq masked", irq_o, 1'b0);
    rd_reg(`TSE_OFF_INTF);
    chk("masked flag", rd_v, 32'h2);
    // unmapped place ignores writes and reads zero
    wr_reg(8'h50, 32'hffffffff);
    rd_reg(8'h50);
    chk("unmapped", rd_v, 32'h0);
    complete_run;
  end
endmodule
